// ---- hw/adc_sar_powerfail_ctrl.sv ----
// converter control: registers, sar sequencer and power-fail compare
`timescale 1ns/1ns
module adc_sar_powerfail_ctrl
    import adc_sar_pkg::*;
(
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst_b,
    // register access
    input  wire sfr_req_t     sfr_req,
    output logic [7:0]        sfr_rdata,
    // analog front end
    output analog_ctrl_t      analog_ctrl,
    input  wire logic         comp_in,
    // conversion end interrupt
    output logic              conversion_end_irq
);
    // register state
    logic              conversion_enable;
    logic [2:0]        conv_time_sel;
    logic [CHAN_W-1:0] channel_sel;
    logic              compare_enable;
    logic              compare_polarity;
    logic [7:0]        compare_threshold;
    logic [7:0]        conversion_result;
    // sequencer state
    conv_state_t       state;
    logic [7:0]        approximation_register;
    logic [2:0]        bit_idx;
    logic [1:0]        sample_cnt;
    logic              first_pending;
    logic              comp_meta;
    logic              comp_sync;
    // decode
    logic              wr_mode;
    logic              wr_chan;
    logic              wr_pfm;
    logic              wr_thr;
    logic              restart;
    logic              tick;
    logic              conv_done;
    logic              cond_met;
    logic [7:0]        next_sar;

    // write strobes per register
    assign wr_mode = sfr_req.wr && sfr_req.addr == ADDR_MODE;
    assign wr_chan = sfr_req.wr && sfr_req.addr == ADDR_CHAN;
    assign wr_pfm  = sfr_req.wr && sfr_req.addr == ADDR_PFM;
    assign wr_thr  = sfr_req.wr && sfr_req.addr == ADDR_THR;
    // a mode or channel write throws away the conversion in flight
    assign restart = wr_mode || wr_chan;

    // mode register; spare bits are not stored and read back as zero
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            conversion_enable <= 1'b0;
            conv_time_sel     <= 3'h0;
        end else if (wr_mode) begin
            conversion_enable <= sfr_req.wdata[MODE_ENABLE_BIT];
            conv_time_sel     <= sfr_req.wdata[MODE_TIME_LSB +: 3];
        end
    end

    // channel register
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            channel_sel <= '0;
        end else if (wr_chan) begin
            channel_sel <= sfr_req.wdata[CHAN_W-1:0];
        end
    end

    // compare mode and threshold registers
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            compare_enable    <= 1'b0;
            compare_polarity  <= 1'b0;
            compare_threshold <= RESET_VAL;
        end else begin
            if (wr_pfm) begin
                compare_enable   <= sfr_req.wdata[PFM_ENABLE_BIT];
                compare_polarity <= sfr_req.wdata[PFM_POL_BIT];
            end
            if (wr_thr) begin
                compare_threshold <= sfr_req.wdata;
            end
        end
    end

    // read data, registered one cycle after the read strobe
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sfr_rdata <= RESET_VAL;
        end else if (sfr_req.rd) begin
            case (sfr_req.addr)
                ADDR_MODE:   sfr_rdata <= {conversion_enable, 1'b0,
                                           conv_time_sel, 3'h0};
                ADDR_CHAN:   sfr_rdata <= {5'h00, channel_sel};
                ADDR_PFM:    sfr_rdata <= {compare_enable, compare_polarity,
                                           6'h00};
                ADDR_THR:    sfr_rdata <= compare_threshold;
                ADDR_RESULT: sfr_rdata <= conversion_result;
                default:     sfr_rdata <= RESET_VAL;
            endcase
        end
    end

    // comparator crosses from the analog side: two flops before use
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            comp_meta <= 1'b0;
            comp_sync <= 1'b0;
        end else begin
            comp_meta <= comp_in;
            comp_sync <= comp_meta;
        end
    end

    // slot pacing; idle holds the timer so each conversion starts aligned
    adc_slot_timer #(
        .W       (SLOT_W)
    ) u_slot_timer (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .restart (restart || state == ST_IDLE),
        .load    (slot_len(conv_time_sel)),
        .tick    (tick)
    );

    // trial bit stays set only if the input is at or above the tap
    always_comb begin
        next_sar = approximation_register;
        if (!comp_sync) begin
            next_sar[bit_idx] = 1'b0;
        end
    end

    // lsb decided: the conversion ends unless a write aborts it
    assign conv_done = state == ST_CONVERT && tick && bit_idx == 3'h0
                       && !restart;

    // sequencer: sample, then one slot per bit from msb down
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state                  <= ST_IDLE;
            approximation_register <= 8'h00;
            bit_idx                <= 3'h7;
            sample_cnt             <= 2'h0;
        end else if (restart || !conversion_enable) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    state      <= ST_SAMPLE;
                    sample_cnt <= 2'h0;
                end
                ST_SAMPLE: begin
                    if (tick) begin
                        sample_cnt <= sample_cnt + 2'h1;
                        if (sample_cnt == 2'(SAMPLE_SLOTS - 1)) begin
                            state                  <= ST_CONVERT;
                            bit_idx                <= 3'h7;
                            approximation_register <= 8'h80;
                        end
                    end
                end
                ST_CONVERT: begin
                    if (tick) begin
                        if (bit_idx == 3'h0) begin
                            approximation_register <= next_sar;
                            state      <= ST_SAMPLE;
                            sample_cnt <= 2'h0;
                        end else begin
                            approximation_register <= next_sar
                                | (8'h01 << (bit_idx - 3'h1));
                            bit_idx <= bit_idx - 3'h1;
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // result load at the end of each conversion
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            conversion_result <= RESET_VAL;
        end else if (conv_done) begin
            conversion_result <= next_sar;
        end
    end

    // first result after enabling is unreliable, so compare mode skips it
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            first_pending <= 1'b1;
        end else if (wr_mode && sfr_req.wdata[MODE_ENABLE_BIT]
                     && !conversion_enable) begin
            first_pending <= 1'b1;
        end else if (conv_done) begin
            first_pending <= 1'b0;
        end
    end

    // compare the fresh result, not the stale register
    assign cond_met = compare_polarity ? (next_sar < compare_threshold)
                                       : (next_sar >= compare_threshold);

    // one-cycle interrupt pulse on the same edge as the result load
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            conversion_end_irq <= 1'b0;
        end else if (!compare_enable) begin
            conversion_end_irq <= conv_done;
        end else begin
            conversion_end_irq <= conv_done && !first_pending
                                  && cond_met;
        end
    end

    // analog front end: hold while resolving bits
    assign analog_ctrl.hold     = state == ST_CONVERT;
    assign analog_ctrl.channel  = channel_sel;
    assign analog_ctrl.tap_code = approximation_register;
endmodule : adc_sar_powerfail_ctrl

// ---- hw/adc_sar_pkg.sv ----
// constants, types and timing for the successive-approximation converter
package adc_sar_pkg;
    // register byte addresses
    localparam logic [15:0] ADDR_MODE    = 16'hFF98;
    localparam logic [15:0] ADDR_CHAN    = 16'hFF99;
    localparam logic [15:0] ADDR_PFM     = 16'hFF9A;
    localparam logic [15:0] ADDR_THR     = 16'hFF9B;
    localparam logic [15:0] ADDR_RESULT  = 16'hFF9C;
    // field positions
    localparam int MODE_ENABLE_BIT = 7;
    localparam int MODE_TIME_LSB   = 3;
    localparam int PFM_ENABLE_BIT  = 7;
    localparam int PFM_POL_BIT     = 6;
    localparam int CHAN_W          = 3;
    localparam int RES_BITS        = 8;
    // reset values
    localparam logic [7:0] RESET_VAL = 8'h00;
    // conversion clock counts per time code
    localparam int CONV_CLKS_144 = 144;
    localparam int CONV_CLKS_120 = 120;
    localparam int CONV_CLKS_96  = 96;
    localparam int CONV_CLKS_72  = 72;
    localparam int CONV_CLKS_60  = 60;
    localparam int CONV_CLKS_48  = 48;
    // a conversion is split into equal slots: sampling, then one per bit
    localparam int SAMPLE_SLOTS   = 4;
    localparam int SLOTS_PER_CONV = SAMPLE_SLOTS + RES_BITS;
    localparam int SLOT_W         = 4;

    // slot length in clocks for a time code; prohibited codes run slowest
    function automatic logic [SLOT_W-1:0] slot_len(input logic [2:0] code);
        case (code)
            3'h1:    slot_len = SLOT_W'(CONV_CLKS_120 / SLOTS_PER_CONV);
            3'h2:    slot_len = SLOT_W'(CONV_CLKS_96 / SLOTS_PER_CONV);
            3'h4:    slot_len = SLOT_W'(CONV_CLKS_72 / SLOTS_PER_CONV);
            3'h5:    slot_len = SLOT_W'(CONV_CLKS_60 / SLOTS_PER_CONV);
            3'h6:    slot_len = SLOT_W'(CONV_CLKS_48 / SLOTS_PER_CONV);
            default: slot_len = SLOT_W'(CONV_CLKS_144 / SLOTS_PER_CONV);
        endcase
    endfunction : slot_len

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_SAMPLE  = 2'b01,
        ST_CONVERT = 2'b10
    } conv_state_t;

    // register access request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } sfr_req_t;

    // drive to the analog front end
    typedef struct packed {
        logic              hold;
        logic [CHAN_W-1:0] channel;
        logic [7:0]        tap_code;
    } analog_ctrl_t;
endpackage : adc_sar_pkg

// ---- hw/adc_slot_timer.sv ----
// slot timer: one-cycle enable pulse every load clocks
`timescale 1ns/1ns
module adc_slot_timer #(
    parameter int W = 4
) (
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst_b,
    // control
    input  wire logic         restart,
    input  wire logic [W-1:0] load,
    // slot end pulse
    output logic              tick
);
    logic [W-1:0] cnt;

    // down counter; restart realigns so a new slot is a full length
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= '0;
        end else if (restart || cnt == '0) begin
            cnt <= load - W'(1);
        end else begin
            cnt <= cnt - W'(1);
        end
    end

    assign tick = !restart && cnt == '0;
endmodule : adc_slot_timer

// ---- bench/adc_sar_powerfail_ctrl_monitor.sv ----
// assertion checker watching the converter control ports
`timescale 1ns/1ns
module adc_sar_powerfail_ctrl_monitor
    import adc_sar_pkg::*;
(
    // clock and reset
    input wire logic         sys_clk,
    input wire logic         rst_b,
    // register access
    input wire sfr_req_t     sfr_req,
    input wire logic [7:0]   sfr_rdata,
    // analog front end
    input wire analog_ctrl_t analog_ctrl,
    input wire logic         comp_in,
    // conversion end interrupt
    input wire logic         conversion_end_irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    logic       en;
    logic       ctl_wr;
    logic [2:0] wd_ch;
    // writes that abort a running conversion
    assign ctl_wr = sfr_req.wr && (sfr_req.addr == ADDR_MODE
                    || sfr_req.addr == ADDR_CHAN);
    assign wd_ch = sfr_req.wdata[2:0];
    // shadow enable bit, so stop checks need no design internals
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            en <= 1'b0;
        end else if (sfr_req.wr && sfr_req.addr == ADDR_MODE) begin
            en <= sfr_req.wdata[7];
        end
    end
    property p_irq_pulse;
        conversion_end_irq |=> !conversion_end_irq;
    endproperty
    property p_reset_zero;
        $rose(rst_b) |-> sfr_rdata == 8'h00 && !conversion_end_irq
            && analog_ctrl == '0;
    endproperty
    property p_stop;
        !en && !$past(en) |-> !conversion_end_irq;
    endproperty
    property p_abort;
        ctl_wr |=> !analog_ctrl.hold;
    endproperty
    property p_tap_msb;
        $rose(analog_ctrl.hold) |-> analog_ctrl.tap_code == 8'h80;
    endproperty
    property p_hold_len;
        $rose(analog_ctrl.hold) ##0 (!ctl_wr)[*8] |-> analog_ctrl.hold;
    endproperty
    property p_irq_after_hold;
        conversion_end_irq |-> $past(analog_ctrl.hold) && !analog_ctrl.hold;
    endproperty
    property p_channel;
        sfr_req.wr && sfr_req.addr == ADDR_CHAN
            |=> analog_ctrl.channel == $past(wd_ch);
    endproperty
    property p_rd_mode;
        sfr_req.rd && sfr_req.addr == ADDR_MODE |=> sfr_rdata[7] == $past(en);
    endproperty
    a_irq_pulse: assert property (p_irq_pulse)
        else $error("irq pulse longer than one cycle");
    a_reset_zero: assert property (p_reset_zero)
        else $error("outputs not cleared by reset");
    a_stop: assert property (p_stop)
        else $error("irq while conversion stopped");
    a_abort: assert property (p_abort)
        else $error("conversion not aborted by write");
    a_tap_msb: assert property (p_tap_msb)
        else $error("first trial code is not msb");
    a_hold_len: assert property (p_hold_len)
        else $error("bit phase ended too early");
    a_irq_after_hold: assert property (p_irq_after_hold)
        else $error("irq not at end of bit phase");
    a_channel: assert property (p_channel)
        else $error("channel output not from register");
    a_rd_mode: assert property (p_rd_mode)
        else $error("enable bit read back wrong");
    cover property (conversion_end_irq);
    cover property (ctl_wr && analog_ctrl.hold);
    cover property ($rose(analog_ctrl.hold));
endmodule : adc_sar_powerfail_ctrl_monitor

// ---- bench/adc_analog_model.sv ----
// analog front end model: sample-hold, tap string and comparator
`timescale 1ns/1ns
module adc_analog_model
    import adc_sar_pkg::*;
(
    // clock
    input wire logic         sys_clk,
    // control from the converter
    input wire analog_ctrl_t analog_ctrl,
    // input n level in bits 8n+7..8n
    input wire logic [63:0]  vin_all,
    // comparator output
    output logic             comp_in
);
    logic [7:0] held = 8'h00;
    logic       junk = 1'b0;
    // track the selected input until hold, then freeze it
    always @(posedge sys_clk) begin
        junk <= ~junk;
        if (!analog_ctrl.hold) begin
            held <= vin_all[{analog_ctrl.channel, 3'b000} +: 8];
        end
    end
    // outside hold the comparator output means nothing, so it toggles
    assign comp_in = analog_ctrl.hold ?
        (held >= analog_ctrl.tap_code) : junk;
endmodule : adc_analog_model

// ---- bench/adc_sar_powerfail_ctrl_tb.sv ----
// self-checking bench for the converter control
`timescale 1ns/1ns
module adc_sar_powerfail_ctrl_tb;
    import adc_sar_pkg::*;
    logic         sys_clk = 1'b0;
    logic         rst_b = 1'b0;
    sfr_req_t     sfr_req = '0;
    logic [7:0]   sfr_rdata;
    analog_ctrl_t analog_ctrl;
    logic         comp_in;
    logic         conversion_end_irq;
    logic [63:0]  vin_all = '0;
    logic [31:0]  lfsr = 32'h05CA1314;
    logic [7:0]   exp_q[$];
    logic [2:0]   codes[6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
    logic [7:0]   clks[6] = '{8'h90, 8'h78, 8'h60, 8'h48, 8'h3C, 8'h30};
    logic [7:0]   pf_m[5] = '{8'h00, 8'h80, 8'h80, 8'hC0, 8'hC0};
    logic [7:0]   pf_t[5] = '{8'h00, 8'h7C, 8'h7D, 8'h7D, 8'h7C};
    logic [7:0]   pf_n[5] = '{8'h04, 8'h03, 8'h00, 8'h03, 8'h00};
    int           n_fail = 0;
    int           comparisons = 0;
    int           n_irq = 0;
    int           cyc = 0;
    int           t_irq = 0;
    int           t0, k, k0;
    always #2 sys_clk = ~sys_clk;
    adc_sar_powerfail_ctrl u_dut (.sys_clk(sys_clk), .rst_b(rst_b),
        .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .comp_in(comp_in),
        .analog_ctrl(analog_ctrl), .conversion_end_irq(conversion_end_irq));
    adc_analog_model u_model (.sys_clk(sys_clk), .analog_ctrl(analog_ctrl),
        .vin_all(vin_all), .comp_in(comp_in));
    // count interrupts and stamp the cycle of the latest one
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (conversion_end_irq === 1'b1) begin
            n_irq <= n_irq + 1;
            t_irq <= cyc;
        end
    end
    function automatic logic [31:0] next_lfsr(input logic [31:0] s);
        next_lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : next_lfsr
    task automatic check(input string nm, input logic [7:0] seen,
                         input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        sfr_req = '{1'b1, 1'b0, a, d};
        @(negedge sys_clk);
        sfr_req.wr = 1'b0;
    endtask : wr
    // expected read data is queued before the strobe goes out
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(negedge sys_clk);
        sfr_req = '{1'b0, 1'b1, a, 8'h00};
        @(negedge sys_clk);
        sfr_req.rd = 1'b0;
    endtask : rd
    task automatic wait_irq(input int n);
        for (int i = 0; i < 2000 && n_irq < n; i++) begin
            @(negedge sys_clk);
        end
    endtask : wait_irq
    // read data is valid the cycle after the strobe edge
    always @(posedge sys_clk) begin
        if (sfr_req.rd === 1'b1) begin
            @(negedge sys_clk);
            check("rdata", sfr_rdata, exp_q.pop_front());
        end
    end
    initial begin
        repeat (12) @(posedge sys_clk);
        @(negedge sys_clk);
        rst_b = 1'b1;
        rd(ADDR_MODE, 8'h00);
        rd(ADDR_CHAN, 8'h00);
        rd(ADDR_PFM, 8'h00);
        rd(ADDR_THR, 8'h00);
        rd(ADDR_RESULT, 8'h00);
        wr(ADDR_THR, 8'hA5);
        rd(ADDR_THR, 8'hA5);
        wr(ADDR_RESULT, 8'h5A);
        rd(ADDR_RESULT, 8'h00);
        // every permitted time code, each on its own channel with a random level
        for (k = 0; k < 6; k++) begin
            lfsr = next_lfsr(lfsr);
            vin_all[k*8 +: 8] = lfsr[7:0];
            wr(ADDR_CHAN, 8'(k));
            // the model settles within a cycle, so even the shortest code
            // leaves the comparator its full settling margin
            wr(ADDR_MODE, {2'b10, codes[k], 3'b000});
            k0 = n_irq;
            wait_irq(k0 + 1);
            t0 = t_irq;
            wait_irq(k0 + 2);
            check("period", 8'(t_irq - t0), clks[k]);
            rd(ADDR_RESULT, lfsr[7:0]);
            rd(ADDR_CHAN, 8'(k));
        end
        // stopping: no interrupt may follow
        wr(ADDR_MODE, 8'h30);
        @(negedge sys_clk);
        k0 = n_irq;
        repeat (300) @(negedge sys_clk);
        check("stop_irqs", 8'(n_irq - k0), 8'h00);
        rd(ADDR_MODE, 8'h30);
        // compare modes: four conversions end inside each window
        vin_all[23:16] = 8'h7C;
        wr(ADDR_CHAN, 8'h02);
        for (k = 0; k < 5; k++) begin
            wr(ADDR_MODE, 8'h30);
            wr(ADDR_PFM, pf_m[k]);
            wr(ADDR_THR, pf_t[k]);
            k0 = n_irq;
            wr(ADDR_MODE, 8'hB0);
            repeat (212) @(negedge sys_clk);
            check("pf_irqs", 8'(n_irq - k0), pf_n[k]);
        end
        // channel write in the bit phase restarts the conversion
        wr(ADDR_PFM, 8'h00);
        k0 = n_irq;
        wait_irq(k0 + 1);
        repeat (20) @(negedge sys_clk);
        wr(ADDR_CHAN, 8'h02);
        t0 = cyc;
        k0 = n_irq;
        wait_irq(k0 + 1);
        check("restart", 8'(t_irq - t0 >= 45 && t_irq - t0 <= 55),
              8'h01);
        end_sim();
    end
    // watchdog: the run needs some 2700 cycles
    initial begin
        #100000;
        n_fail++;
        end_sim();
    end
endmodule : adc_sar_powerfail_ctrl_tb
bind adc_sar_powerfail_ctrl adc_sar_powerfail_ctrl_monitor u_mon (
    .sys_clk(sys_clk), .rst_b(rst_b), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .analog_ctrl(analog_ctrl), .comp_in(comp_in),
    .conversion_end_irq(conversion_end_irq));
